// [dsas_pkg.sv]
`default_nettype none
package dsas_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_SWITCH = 5'h04;
  localparam logic [4:0] OFF_RESULT = 5'h08;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RES_LSB = 2;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_MUX_ON = 7;
  localparam int CTRL_START = 8;
  localparam int CTRL_STOP = 9;
  localparam int CTRL_DONE = 16;
  localparam int CTRL_BUSY = 17;

  // ****************************************************************
  // interrupt status and mask fields
  // ****************************************************************
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_N = 2;

  // ****************************************************************
  // modes, resolutions, states
  // ****************************************************************
  typedef enum logic [1:0] {MODE_SINGLE, MODE_MULTI, MODE_CONT, MODE_TURBO} dsas_mode_t;
  typedef enum logic [1:0] {RES_8, RES_12, RES_16, RES_20} dsas_res_t;
  typedef enum logic {ST_IDLE, ST_RUN} dsas_state_t;

  localparam dsas_mode_t MODE_RST = MODE_SINGLE;
  localparam dsas_res_t RES_RST = RES_16;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [7:0] SW_RST = 8'h00;
  localparam logic [IRQ_N-1:0] MASK_RST = 2'h0;

  // ****************************************************************
  // decimator sizing
  // ****************************************************************
  localparam int SINC_ORDER = 4;
  localparam logic [1:0] PRIME_CONV = 2'h3;
  localparam int ACC_W = 61;
  localparam int RES_W = 20;
  localparam int MUX_N = 8;
  localparam int SW_N = 8;
  localparam int DEC_CNT_W = 15;
  // modulator rate assumed 6.144 MHz; ratios give 187.5 / 48 k / 192 k / 384 k sps
  localparam int MOD_RATE_HZ = 6144000;
  localparam int SPS_20 = 187;
  localparam int SPS_16 = 48000;
  localparam int SPS_12 = 192000;
  localparam int SPS_8 = 384000;
  localparam int DEC_LOG2_20 = 15;
  localparam int DEC_LOG2_16 = 7;
  localparam int DEC_LOG2_12 = 5;
  localparam int DEC_LOG2_8 = 4;
  localparam int RES_BITS_20 = 20;
  localparam int RES_BITS_16 = 16;
  localparam int RES_BITS_12 = 12;
  localparam int RES_BITS_8 = 8;

endpackage : dsas_pkg
`default_nettype wire

// [dsas_top.sv]
// Functional notes
// - four selectable modes: single, multi, continuous, multi turbo.
// - conversion starts on control start bit or start-of-conversion strobe.
// - completion sets a done status bit readable in the control register.
// - end-of-conversion output high from completion until result read by CPU or DMA.
// - pipelined decimator output depends on the last four decimated samples.
// - results invalid after mux change until the fourth sample following it.
// - resolutions 20/16/12/8 bits at 187, 48k, 192k, 384k sps.
// - decimator turns oversampled serial bitstream into parallel results.
// - nominal setting is 16 bits at 48 ksps.
// - input mux enables at most one connection; switch groups may enable many.
// - single mode: standby, four conversions per start, done after fourth, standby.
// - continuous: first result after three priming conversions, then every sample.
// - multi: decimator reset and re-primed between samples, next starts automatically.
// - turbo: like multi up to 16 bits; at 20 bits no reset between samples.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dsas_top (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic SOC_I,
  input wire logic MOD_BIT_I,
  input wire logic MOD_STB_I,
  input wire logic DMA_ACK_I,
  output logic EOC_O,
  output logic [dsas_pkg::RES_W-1:0] RESULT_O,
  output logic [dsas_pkg::MUX_N-1:0] MUX_EN_O,
  output logic [dsas_pkg::SW_N-1:0] SW_EN_O,
  output logic BUSY_O,
  output logic IRQ_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic soc_meta;
    logic soc_sync;
    logic soc_prev;
    logic ack;
    logic [31:0] rdata;
    dsas_pkg::dsas_state_t st;
    dsas_pkg::dsas_mode_t mode;
    dsas_pkg::dsas_res_t res;
    logic [2:0] mux_sel;
    logic mux_on;
    logic [dsas_pkg::MUX_N-1:0] mux_en;
    logic [dsas_pkg::SW_N-1:0] sw_en;
    logic [1:0] samples;
    logic [dsas_pkg::DEC_CNT_W-1:0] dec_cnt;
    logic [dsas_pkg::SINC_ORDER-1:0][dsas_pkg::ACC_W-1:0] integ;
    logic [dsas_pkg::SINC_ORDER-1:0][dsas_pkg::ACC_W-1:0] combd;
    logic eoc;
    logic [dsas_pkg::RES_W-1:0] result;
    logic [dsas_pkg::IRQ_N-1:0] irq_stat;
    logic [dsas_pkg::IRQ_N-1:0] irq_mask;
  } dsas_regs_t;

  dsas_regs_t s_reg;
  dsas_regs_t s_next;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic [dsas_pkg::DEC_CNT_W-1:0] dec_last(input dsas_pkg::dsas_res_t r);
    int lg;
    case (r)
      dsas_pkg::RES_8: lg = dsas_pkg::DEC_LOG2_8;
      dsas_pkg::RES_12: lg = dsas_pkg::DEC_LOG2_12;
      dsas_pkg::RES_16: lg = dsas_pkg::DEC_LOG2_16;
      default: lg = dsas_pkg::DEC_LOG2_20;
    endcase
    return dsas_pkg::DEC_CNT_W'((32'h1 << lg) - 32'h1);
  endfunction : dec_last

  // sinc4 output has 4*log2(R) bits; keep the top res bits, saturating full scale
  function automatic logic [dsas_pkg::RES_W-1:0] scale(input logic [dsas_pkg::ACC_W-1:0] v,
                                                       input dsas_pkg::dsas_res_t r);
    int lg;
    int rb;
    logic [dsas_pkg::ACC_W-1:0] t;
    logic [dsas_pkg::ACC_W-1:0] mx;
    case (r)
      dsas_pkg::RES_8: begin
        lg = dsas_pkg::DEC_LOG2_8;
        rb = dsas_pkg::RES_BITS_8;
      end
      dsas_pkg::RES_12: begin
        lg = dsas_pkg::DEC_LOG2_12;
        rb = dsas_pkg::RES_BITS_12;
      end
      dsas_pkg::RES_16: begin
        lg = dsas_pkg::DEC_LOG2_16;
        rb = dsas_pkg::RES_BITS_16;
      end
      default: begin
        lg = dsas_pkg::DEC_LOG2_20;
        rb = dsas_pkg::RES_BITS_20;
      end
    endcase
    t = v >> (dsas_pkg::SINC_ORDER * lg - rb);
    mx = (dsas_pkg::ACC_W'(1) << rb) - dsas_pkg::ACC_W'(1);
    if (t > mx) begin
      t = mx;
    end
    return t[dsas_pkg::RES_W-1:0];
  endfunction : scale

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
    return m;
  endfunction : be_merge

  // ****************************************************************
  // events
  // ****************************************************************
  logic soc_edge;
  logic wr_ack;
  logic rd_ack;
  logic dec_evt;
  logic res_evt;
  logic res_clr;
  logic start_sw;
  logic stop_sw;
  logic start_evt;
  logic mux_chg;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_wr;
  logic [31:0] sw_wr;

  assign soc_edge = s_reg.soc_sync & ~s_reg.soc_prev;
  assign wr_ack = AVS_WRITE_I & s_reg.ack;
  assign rd_ack = AVS_READ_I & s_reg.ack;
  assign dec_evt = (s_reg.st == dsas_pkg::ST_RUN) & MOD_STB_I & (s_reg.dec_cnt == dec_last(s_reg.res));
  assign res_evt = dec_evt & (s_reg.samples == dsas_pkg::PRIME_CONV);
  assign res_clr = DMA_ACK_I | (rd_ack & (AVS_ADDRESS_I == dsas_pkg::OFF_RESULT));
  assign ctrl_word = {14'h0000, (s_reg.st == dsas_pkg::ST_RUN), s_reg.eoc, 6'h00, 2'h0,
                      s_reg.mux_on, s_reg.mux_sel, s_reg.res, s_reg.mode};
  assign ctrl_wr = be_merge(ctrl_word, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  assign sw_wr = be_merge({24'h000000, s_reg.sw_en}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  assign start_sw = wr_ack & (AVS_ADDRESS_I == dsas_pkg::OFF_CTRL) & ctrl_wr[dsas_pkg::CTRL_START];
  assign stop_sw = wr_ack & (AVS_ADDRESS_I == dsas_pkg::OFF_CTRL) & ctrl_wr[dsas_pkg::CTRL_STOP];
  assign start_evt = start_sw | soc_edge;
  assign mux_chg = wr_ack & (AVS_ADDRESS_I == dsas_pkg::OFF_CTRL) &
                   (ctrl_wr[dsas_pkg::CTRL_SEL_LSB +: 4] != {s_reg.mux_on, s_reg.mux_sel});

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [dsas_pkg::ACC_W-1:0] c;
    logic [dsas_pkg::ACC_W-1:0] t;
    logic dec_clr;
    c = '0;
    t = '0;
    dec_clr = 1'b0;
    s_next = s_reg;
    s_next.soc_meta = SOC_I;
    s_next.soc_sync = s_reg.soc_meta;
    s_next.soc_prev = s_reg.soc_sync;

    // bus slave: one wait cycle, answer on the second
    s_next.ack = (AVS_READ_I | AVS_WRITE_I) & ~s_reg.ack;
    if (AVS_READ_I & ~s_reg.ack) begin
      case (AVS_ADDRESS_I)
        dsas_pkg::OFF_CTRL: s_next.rdata = ctrl_word;
        dsas_pkg::OFF_SWITCH: s_next.rdata = {24'h000000, s_reg.sw_en};
        dsas_pkg::OFF_RESULT: s_next.rdata = {12'h000, s_reg.result};
        dsas_pkg::OFF_IRQ_STAT: s_next.rdata = {30'h00000000, s_reg.irq_stat};
        dsas_pkg::OFF_IRQ_MASK: s_next.rdata = {30'h00000000, s_reg.irq_mask};
        default: s_next.rdata = 32'h00000000;
      endcase
    end

    // sinc4 decimator: integrators at modulator rate, combs at output rate
    if ((s_reg.st == dsas_pkg::ST_RUN) & MOD_STB_I) begin
      s_next.integ[0] = s_reg.integ[0] + {{(dsas_pkg::ACC_W-1){1'b0}}, MOD_BIT_I};
      for (int k = 1; k < dsas_pkg::SINC_ORDER; k++) begin
        s_next.integ[k] = s_reg.integ[k] + s_reg.integ[k-1];
      end
      s_next.dec_cnt = dec_evt ? '0 : s_reg.dec_cnt + 1'b1;
    end
    if (dec_evt) begin
      c = s_reg.integ[dsas_pkg::SINC_ORDER-1];
      for (int k = 0; k < dsas_pkg::SINC_ORDER; k++) begin
        t = c - s_reg.combd[k];
        s_next.combd[k] = c;
        c = t;
      end
      if (s_reg.samples != dsas_pkg::PRIME_CONV) begin
        s_next.samples = s_reg.samples + 2'h1;
      end
    end
    if (res_evt) begin
      s_next.result = scale(c, s_reg.res);
      case (s_reg.mode)
        dsas_pkg::MODE_SINGLE: begin
          s_next.st = dsas_pkg::ST_IDLE;
          dec_clr = 1'b1;
        end
        dsas_pkg::MODE_MULTI: dec_clr = 1'b1;
        dsas_pkg::MODE_TURBO: dec_clr = (s_reg.res != dsas_pkg::RES_20);
        default: dec_clr = 1'b0;
      endcase
    end

    // completion flag: a new result wins over a same-cycle read
    s_next.eoc = (s_reg.eoc & ~res_clr) | res_evt;
    s_next.irq_stat = s_reg.irq_stat;
    if (wr_ack & (AVS_ADDRESS_I == dsas_pkg::OFF_IRQ_STAT)) begin
      s_next.irq_stat = s_reg.irq_stat &
                        ~(AVS_WRITEDATA_I[dsas_pkg::IRQ_N-1:0] & {dsas_pkg::IRQ_N{AVS_BYTEENABLE_I[0]}});
    end
    if (res_evt) begin
      s_next.irq_stat[dsas_pkg::IRQ_DONE] = 1'b1;
      s_next.irq_stat[dsas_pkg::IRQ_OVERRUN] = s_next.irq_stat[dsas_pkg::IRQ_OVERRUN] | (s_reg.eoc & ~res_clr);
    end

    // register writes
    if (wr_ack) begin
      case (AVS_ADDRESS_I)
        dsas_pkg::OFF_CTRL: begin
          s_next.mode = dsas_pkg::dsas_mode_t'(ctrl_wr[dsas_pkg::CTRL_MODE_LSB +: 2]);
          s_next.res = dsas_pkg::dsas_res_t'(ctrl_wr[dsas_pkg::CTRL_RES_LSB +: 2]);
          s_next.mux_sel = ctrl_wr[dsas_pkg::CTRL_SEL_LSB +: 3];
          s_next.mux_on = ctrl_wr[dsas_pkg::CTRL_MUX_ON];
          s_next.mux_en = ctrl_wr[dsas_pkg::CTRL_MUX_ON] ?
                          dsas_pkg::MUX_N'(1) << ctrl_wr[dsas_pkg::CTRL_SEL_LSB +: 3] : '0;
        end
        dsas_pkg::OFF_SWITCH: s_next.sw_en = sw_wr[dsas_pkg::SW_N-1:0];
        dsas_pkg::OFF_IRQ_MASK: begin
          if (AVS_BYTEENABLE_I[0]) begin
            s_next.irq_mask = AVS_WRITEDATA_I[dsas_pkg::IRQ_N-1:0];
          end
        end
        default: s_next.mode = s_reg.mode;
      endcase
    end

    // sequencing: idle takes a start, run ignores it
    case (s_reg.st)
      dsas_pkg::ST_IDLE: begin
        if (start_evt) begin
          s_next.st = dsas_pkg::ST_RUN;
          dec_clr = 1'b1;
        end
      end
      dsas_pkg::ST_RUN: begin
        if (stop_sw) begin
          s_next.st = dsas_pkg::ST_IDLE;
          dec_clr = 1'b1;
        end
      end
      default: s_next.st = dsas_pkg::ST_IDLE;
    endcase

    if (dec_clr) begin
      s_next.integ = '0;
      s_next.combd = '0;
      s_next.dec_cnt = '0;
      s_next.samples = 2'h0;
    end
    if (mux_chg) begin
      s_next.samples = 2'h0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_reg <= '0;
      s_reg.st <= dsas_pkg::ST_IDLE;
      s_reg.mode <= dsas_pkg::MODE_RST;
      s_reg.res <= dsas_pkg::RES_RST;
      s_reg.mux_sel <= dsas_pkg::SEL_RST;
      s_reg.sw_en <= dsas_pkg::SW_RST;
      s_reg.irq_mask <= dsas_pkg::MASK_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~s_reg.ack;
  assign AVS_READDATA_O = s_reg.rdata;
  assign EOC_O = s_reg.eoc;
  assign RESULT_O = s_reg.result;
  assign MUX_EN_O = s_reg.mux_en;
  assign SW_EN_O = s_reg.sw_en;
  assign BUSY_O = (s_reg.st == dsas_pkg::ST_RUN);
  assign IRQ_O = |(s_reg.irq_stat & s_reg.irq_mask);

  // comb output tap for the result check
  logic [dsas_pkg::ACC_W-1:0] c_dbg;
  always_comb begin
    c_dbg = s_reg.integ[dsas_pkg::SINC_ORDER-1];
    for (int k = 0; k < dsas_pkg::SINC_ORDER; k++) begin
      c_dbg = c_dbg - s_reg.combd[k];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESETN_I);

  sequence s_result;
    res_evt;
  endsequence

  sequence s_rerun;
    (s_reg.samples == 2'h0) && (s_reg.st == dsas_pkg::ST_RUN);
  endsequence

  a_eoc_hold: assert property (EOC_O && !res_clr |=> EOC_O)
    else $error("done flag dropped before the result was read");
  a_eoc_clear: assert property (EOC_O && res_clr && !res_evt |=> !EOC_O)
    else $error("done flag not cleared by result read");
  a_result_done: assert property (s_result |=> EOC_O && s_reg.irq_stat[dsas_pkg::IRQ_DONE]
                                    && (RESULT_O == $past(scale(c_dbg, s_reg.res))))
    else $error("completion did not raise done with the new result");
  a_mux_onehot: assert property ($onehot0(MUX_EN_O))
    else $error("more than one mux connection enabled");
  a_busy_ignore: assert property (BUSY_O && start_evt && !stop_sw && !res_evt |=> BUSY_O)
    else $error("start during a conversion disturbed the sequence");
  a_soc_single: assert property (soc_edge |=> !soc_edge)
    else $error("start strobe produced more than one event");
  a_single_stop: assert property (s_result and (s_reg.mode == dsas_pkg::MODE_SINGLE) |=> !BUSY_O)
    else $error("single mode did not return to standby");
  a_multi_reprime: assert property (s_result and (s_reg.mode == dsas_pkg::MODE_MULTI) && !stop_sw |=> s_rerun)
    else $error("multi mode did not re-prime and restart");
  a_cont_keep: assert property (s_result and (s_reg.mode == dsas_pkg::MODE_CONT) && !stop_sw && !mux_chg
                                  |=> BUSY_O && (s_reg.samples == dsas_pkg::PRIME_CONV))
    else $error("continuous mode lost priming after a result");
  a_mux_invalid: assert property (mux_chg |=> s_reg.samples == 2'h0)
    else $error("mux change did not invalidate the pipeline");

endmodule : dsas_top
`default_nettype wire

// [dsas_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dsas_far_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic bit_i,
  input wire logic clr_i,
  input wire logic eoc_i,
  input wire logic dma_en_i,
  output logic stb_o,
  output logic bit_o,
  output logic ack_o,
  output logic [15:0] cnt_o
);
  // ****************************************************************
  // modulator source and result reader
  // ****************************************************************
  logic [1:0] ph;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph <= 2'h0;
      stb_o <= 1'h0;
      bit_o <= 1'h0;
      ack_o <= 1'h0;
      cnt_o <= 16'h0000;
    end else begin
      ph <= ph + 2'h1;
      stb_o <= en_i && (ph == 2'h3);
      // bit toggles outside strobes so a stale value never looks valid
      bit_o <= (en_i && (ph == 2'h3)) ? bit_i : ~bit_o;
      if (clr_i) begin
        cnt_o <= 16'h0000;
      end else if (stb_o) begin
        cnt_o <= cnt_o + 16'h0001;
      end
      // one-cycle read acknowledge per result
      ack_o <= dma_en_i && eoc_i && !ack_o;
    end
  end
endmodule : dsas_far_model
`default_nettype wire

// [dsas_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, ex, gt); end end
module dsas_top_tb;
  logic CLK_SYS_I = 1'h0;
  logic RESETN_I = 1'h0;
  logic [4:0] AVS_ADDRESS_I = 5'h00;
  logic AVS_READ_I = 1'h0;
  logic AVS_WRITE_I = 1'h0;
  logic [31:0] AVS_WRITEDATA_I = 32'h0;
  logic SOC_I = 1'h0;
  logic [31:0] AVS_READDATA_O;
  logic AVS_WAITREQUEST_O, MOD_BIT_I, MOD_STB_I, DMA_ACK_I, EOC_O, BUSY_O, IRQ_O;
  logic [19:0] RESULT_O;
  logic [7:0] MUX_EN_O, SW_EN_O;
  logic m_en = 1'h0, m_bit = 1'h0, m_clr = 1'h0, m_dma = 1'h0;
  logic [15:0] m_cnt;
  logic [31:0] d;
  int n_errors = 0;
  int total_checks = 0;
  int lg[3] = '{dsas_pkg::DEC_LOG2_8, dsas_pkg::DEC_LOG2_12, dsas_pkg::DEC_LOG2_16};
  int bw[3] = '{dsas_pkg::RES_BITS_8, dsas_pkg::RES_BITS_12, dsas_pkg::RES_BITS_16};

  always #2.5 CLK_SYS_I = ~CLK_SYS_I;

  dsas_top dut (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .SOC_I(SOC_I), .MOD_BIT_I(MOD_BIT_I), .MOD_STB_I(MOD_STB_I), .DMA_ACK_I(DMA_ACK_I), .EOC_O(EOC_O),
    .RESULT_O(RESULT_O), .MUX_EN_O(MUX_EN_O), .SW_EN_O(SW_EN_O), .BUSY_O(BUSY_O), .IRQ_O(IRQ_O));

  dsas_far_model far (.clk_i(CLK_SYS_I), .rst_n_i(RESETN_I), .en_i(m_en), .bit_i(m_bit), .clr_i(m_clr),
    .eoc_i(EOC_O), .dma_en_i(m_dma), .stb_o(MOD_STB_I), .bit_o(MOD_BIT_I), .ack_o(DMA_ACK_I), .cnt_o(m_cnt));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] r, input logic [2:0] s,
    input logic on, input logic go);
    return (32'(m) << dsas_pkg::CTRL_MODE_LSB) | (32'(r) << dsas_pkg::CTRL_RES_LSB) |
      (32'(s) << dsas_pkg::CTRL_SEL_LSB) | (32'(on) << dsas_pkg::CTRL_MUX_ON) | (32'(go) << dsas_pkg::CTRL_START);
  endfunction : cw

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] wd);
    @(posedge CLK_SYS_I);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= wd;
    AVS_WRITE_I <= w;
    AVS_READ_I <= !w;
    @(posedge CLK_SYS_I);
    while (AVS_WAITREQUEST_O !== 1'h0) begin
      @(posedge CLK_SYS_I);
    end
    d = AVS_READDATA_O;
    AVS_WRITE_I <= 1'h0;
    AVS_READ_I <= 1'h0;
  endtask : xfer

  task automatic start(input logic [1:0] m, input logic [1:0] r, input logic [2:0] s, input logic on);
    xfer(1'h1, dsas_pkg::OFF_CTRL, cw(m, r, s, on, 1'h1));
    m_clr <= 1'h1;
    @(posedge CLK_SYS_I);
    m_clr <= 1'h0;
    m_en <= 1'h1;
  endtask : start

  task automatic wait_stb(input int n);
    int i;
    i = 0;
    while (m_cnt < 16'(n) && i < 20000) begin
      @(negedge CLK_SYS_I);
      i++;
    end
    if (i >= 20000) n_errors++;
  endtask : wait_stb

  task automatic wait_eoc(input int n);
    int i;
    i = 0;
    @(negedge CLK_SYS_I);
    while (EOC_O !== 1'h1 && i < 20000) begin
      @(negedge CLK_SYS_I);
      i++;
    end
    if (i >= 20000) n_errors++;
    `CHK("strobes to result", 16'(n), m_cnt)
  endtask : wait_eoc

  task automatic stop_run;
    @(posedge CLK_SYS_I);
    m_en <= 1'h0;
    xfer(1'h1, dsas_pkg::OFF_CTRL, 32'h0000_0200);
    @(negedge CLK_SYS_I);
    `CHK("busy after stop", 1'h0, BUSY_O)
  endtask : stop_run

  // ****************************************************************
  // watchdog
  // ****************************************************************
  initial begin
    #300000;
    n_errors++;
    close_out();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (3) @(posedge CLK_SYS_I);
    RESETN_I <= 1'h1;
    xfer(1'h0, dsas_pkg::OFF_CTRL, 32'h0);
    `CHK("ctrl reset", cw(dsas_pkg::MODE_RST, dsas_pkg::RES_RST, 3'h0, 1'h0, 1'h0), d)
    for (int a = 4; a <= 20; a += 4) begin
      xfer(1'h0, 5'(a), 32'h0);
      `CHK("reg reset", 32'h0, d)
    end
    `CHK("idle outputs", 4'h0, {EOC_O, BUSY_O, IRQ_O, |MUX_EN_O})
    xfer(1'h1, dsas_pkg::OFF_SWITCH, 32'h0000_00A5);
    xfer(1'h0, dsas_pkg::OFF_SWITCH, 32'h0);
    `CHK("switch groups", 8'hA5, SW_EN_O)
    `CHK("switch readback", 32'h0000_00A5, d)
    for (int s = 0; s < 9; s++) begin
      xfer(1'h1, dsas_pkg::OFF_CTRL, cw(2'h0, 2'h0, 3'(s), s < 8, 1'h0));
      @(negedge CLK_SYS_I);
      `CHK("mux one-hot", (s < 8) ? 8'h01 << s : 8'h00, MUX_EN_O)
    end
    m_bit <= 1'h1;
    for (int k = 0; k < 3; k++) begin
      start(dsas_pkg::MODE_SINGLE, 2'(k), 3'h0, 1'h0);
      @(negedge CLK_SYS_I);
      `CHK("busy on start bit", 1'h1, BUSY_O)
      wait_eoc(4 << lg[k]);
      `CHK("full scale", 20'((1 << bw[k]) - 1), RESULT_O)
      repeat (40) @(negedge CLK_SYS_I);
      `CHK("eoc held", 1'h1, EOC_O)
      `CHK("irq masked", k != 0, IRQ_O)
      if (k == 0) xfer(1'h1, dsas_pkg::OFF_IRQ_MASK, 32'h1);
      @(negedge CLK_SYS_I);
      `CHK("irq unmasked", 1'h1, IRQ_O)
      xfer(1'h0, dsas_pkg::OFF_CTRL, 32'h0);
      `CHK("done status", cw(2'h0, 2'(k), 3'h0, 1'h0, 1'h0) | 32'h0001_0000, d)
      xfer(1'h0, dsas_pkg::OFF_RESULT, 32'h0);
      `CHK("result read", 32'((1 << bw[k]) - 1), d)
      xfer(1'h1, dsas_pkg::OFF_IRQ_STAT, 32'h1);
      @(negedge CLK_SYS_I);
      `CHK("eoc and irq clear", 2'h0, {EOC_O, IRQ_O})
      m_en <= 1'h0;
    end
    xfer(1'h1, dsas_pkg::OFF_CTRL, cw(2'h0, 2'h0, 3'h0, 1'h0, 1'h0));
    m_bit <= 1'h0;
    m_dma <= 1'h1;
    SOC_I <= 1'h1;
    for (int i = 0; i < 20 && BUSY_O !== 1'h1; i++) @(posedge CLK_SYS_I);
    `CHK("busy on soc", 1'h1, BUSY_O)
    m_clr <= 1'h1;
    @(posedge CLK_SYS_I);
    m_clr <= 1'h0;
    m_en <= 1'h1;
    wait_stb(32);
    xfer(1'h1, dsas_pkg::OFF_CTRL, cw(2'h0, 2'h0, 3'h0, 1'h0, 1'h1));
    wait_eoc(64);
    `CHK("zero stream", 20'h0, RESULT_O)
    repeat (300) @(negedge CLK_SYS_I);
    `CHK("one start per edge", 2'h0, {BUSY_O, EOC_O})
    @(posedge CLK_SYS_I);
    SOC_I <= 1'h0;
    m_dma <= 1'h0;
    m_en <= 1'h0;
    m_bit <= 1'h1;
    for (int m = 1; m < 4; m += 2) begin
      start(2'(m), dsas_pkg::RES_8, 3'h0, 1'h0);
      wait_eoc(64);
      xfer(1'h0, dsas_pkg::OFF_RESULT, 32'h0);
      wait_eoc(128);
      stop_run();
      xfer(1'h0, dsas_pkg::OFF_RESULT, 32'h0);
    end
    start(dsas_pkg::MODE_CONT, dsas_pkg::RES_8, 3'h0, 1'h0);
    wait_eoc(64);
    xfer(1'h0, dsas_pkg::OFF_RESULT, 32'h0);
    wait_eoc(80);
    wait_stb(96);
    m_en <= 1'h0;
    repeat (4) @(negedge CLK_SYS_I);
    xfer(1'h0, dsas_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK("done and overrun", 32'h3, d)
    xfer(1'h1, dsas_pkg::OFF_IRQ_STAT, 32'h1);
    xfer(1'h0, dsas_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK("overrun kept", 32'h2, d)
    xfer(1'h1, dsas_pkg::OFF_IRQ_STAT, 32'h2);
    xfer(1'h0, dsas_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK("status cleared", 32'h0, d)
    xfer(1'h0, dsas_pkg::OFF_RESULT, 32'h0);
    xfer(1'h1, dsas_pkg::OFF_CTRL, cw(dsas_pkg::MODE_CONT, dsas_pkg::RES_8, 3'h5, 1'h1, 1'h0));
    @(negedge CLK_SYS_I);
    `CHK("mux select", 8'h20, MUX_EN_O)
    m_clr <= 1'h1;
    @(posedge CLK_SYS_I);
    m_clr <= 1'h0;
    m_en <= 1'h1;
    wait_eoc(64);
    stop_run();
    close_out();
  end
endmodule : dsas_top_tb
`default_nettype wire
